// [hw/bus_state_unit.v]
// Bus state unit register set with reset and power-down retention
`timescale 1ns/1ps
`include "bus_state_unit_defs.vh"

module bus_state_unit #(
    parameter [7:0] PRESCALE = 8'h04
) (
    input  wire        ref_clk,
    input  wire        reset,
    input  wire        manual_reset,
    input  wire        standby,
    input  wire        sleep,
    input  wire        wr_en,
    input  wire [3:0]  wr_sel,
    input  wire [15:0] wr_data,
    output wire [15:0] bus_control_one,
    output wire [15:0] bus_control_two,
    output wire [15:0] wait_control_one,
    output wire [15:0] wait_control_two,
    output wire [15:0] memory_control,
    output wire [15:0] second_memory_control,
    output wire [15:0] card_interface_control,
    output wire [15:0] refresh_timer_ctrl_status,
    output wire [15:0] refresh_timer_counter,
    output wire [15:0] refresh_time_constant,
    output wire [15:0] refresh_count,
    output wire [15:0] port_control,
    output wire [15:0] port_data,
    output wire        refresh_request
);

    reg  [15:0] bus_control_one_q;
    reg  [15:0] bus_control_two_q;
    reg  [15:0] wait_control_one_q;
    reg  [15:0] wait_control_two_q;
    reg  [15:0] memory_control_q;
    reg  [15:0] second_memory_control_q;
    reg  [15:0] card_interface_control_q;
    reg  [15:0] ctrl_status_q;
    reg  [15:0] ctrl_status_d;
    reg  [15:0] timer_counter_q;
    reg  [15:0] timer_counter_d;
    reg  [15:0] time_constant_q;
    reg  [15:0] refresh_count_q;
    reg  [15:0] refresh_count_d;
    reg  [15:0] port_control_q;
    reg  [15:0] port_data_q;
    reg  [7:0]  prescale_q;
    reg  [7:0]  prescale_d;
    reg         refresh_request_q;
    reg         refresh_request_d;

    wire        sw_write;
    wire        timer_enabled;
    wire        tick;
    wire        match;
    wire        wr_bus_control_one;
    wire        wr_bus_control_two;
    wire        wr_wait_control_one;
    wire        wr_wait_control_two;
    wire        wr_memory_control;
    wire        wr_second_memory_control;
    wire        wr_card_interface_control;
    wire        wr_refresh_timer_ctrl;
    wire        wr_refresh_timer_counter;
    wire        wr_refresh_time_constant;
    wire        wr_refresh_count;
    wire        wr_port_control;
    wire        wr_port_data;

    // Writes only when awake and out of manual reset
    assign sw_write      = wr_en & ~manual_reset & ~standby & ~sleep;
    assign timer_enabled = ctrl_status_q[`CTRL_CLOCK_SEL_HI:`CTRL_CLOCK_SEL_LO]
                           != `CTRL_CLOCK_SEL_OFF;
    assign tick          = timer_enabled & (prescale_q == PRESCALE - `PRESCALE_ONE);
    assign match         = tick & (timer_counter_q == time_constant_q);

    // Per-register write strobes
    assign wr_bus_control_one        = sw_write & (wr_sel == `SEL_BUS_CONTROL_ONE);
    assign wr_bus_control_two        = sw_write & (wr_sel == `SEL_BUS_CONTROL_TWO);
    assign wr_wait_control_one       = sw_write & (wr_sel == `SEL_WAIT_CONTROL_ONE);
    assign wr_wait_control_two       = sw_write & (wr_sel == `SEL_WAIT_CONTROL_TWO);
    assign wr_memory_control         = sw_write & (wr_sel == `SEL_MEMORY_CONTROL);
    assign wr_second_memory_control  = sw_write & (wr_sel == `SEL_SECOND_MEMORY_CONTROL);
    assign wr_card_interface_control = sw_write & (wr_sel == `SEL_CARD_INTERFACE_CONTROL);
    assign wr_refresh_timer_ctrl     = sw_write & (wr_sel == `SEL_REFRESH_TIMER_CTRL);
    assign wr_refresh_timer_counter  = sw_write & (wr_sel == `SEL_REFRESH_TIMER_COUNTER);
    assign wr_refresh_time_constant  = sw_write & (wr_sel == `SEL_REFRESH_TIME_CONSTANT);
    assign wr_refresh_count          = sw_write & (wr_sel == `SEL_REFRESH_COUNT);
    assign wr_port_control           = sw_write & (wr_sel == `SEL_PORT_CONTROL);
    assign wr_port_data              = sw_write & (wr_sel == `SEL_PORT_DATA);

    // Bus control one
    always @(posedge ref_clk) begin
        if (reset) begin
            bus_control_one_q <= `RST_BUS_CONTROL_ONE;
        end else if (wr_bus_control_one) begin
            bus_control_one_q <= wr_data;
        end
    end

    // Bus control two
    always @(posedge ref_clk) begin
        if (reset) begin
            bus_control_two_q <= `RST_BUS_CONTROL_TWO;
        end else if (wr_bus_control_two) begin
            bus_control_two_q <= wr_data;
        end
    end

    // Wait control one
    always @(posedge ref_clk) begin
        if (reset) begin
            wait_control_one_q <= `RST_WAIT_CONTROL_ONE;
        end else if (wr_wait_control_one) begin
            wait_control_one_q <= wr_data;
        end
    end

    // Wait control two
    always @(posedge ref_clk) begin
        if (reset) begin
            wait_control_two_q <= `RST_WAIT_CONTROL_TWO;
        end else if (wr_wait_control_two) begin
            wait_control_two_q <= wr_data;
        end
    end

    // Memory control
    always @(posedge ref_clk) begin
        if (reset) begin
            memory_control_q <= `RST_MEMORY_CONTROL;
        end else if (wr_memory_control) begin
            memory_control_q <= wr_data;
        end
    end

    // Second memory control
    always @(posedge ref_clk) begin
        if (reset) begin
            second_memory_control_q <= `RST_SECOND_MEMORY_CONTROL;
        end else if (wr_second_memory_control) begin
            second_memory_control_q <= wr_data;
        end
    end

    // Card interface control
    always @(posedge ref_clk) begin
        if (reset) begin
            card_interface_control_q <= `RST_CARD_INTERFACE_CONTROL;
        end else if (wr_card_interface_control) begin
            card_interface_control_q <= wr_data;
        end
    end

    // Refresh time constant
    always @(posedge ref_clk) begin
        if (reset) begin
            time_constant_q <= `RST_REFRESH_TIME_CONSTANT;
        end else if (wr_refresh_time_constant) begin
            time_constant_q <= wr_data;
        end
    end

    // Port control
    always @(posedge ref_clk) begin
        if (reset) begin
            port_control_q <= `RST_PORT_CONTROL;
        end else if (wr_port_control) begin
            port_control_q <= wr_data;
        end
    end

    // Port data has no power-on value
    always @(posedge ref_clk) begin
        if (wr_port_data) begin
            port_data_q <= wr_data;
        end
    end

    // Prescaler: one tick every PRESCALE cycles while enabled
    always @* begin
        prescale_d = prescale_q;
        if (!standby) begin
            if (!timer_enabled || tick) begin
                prescale_d = `PRESCALE_ZERO;
            end else begin
                prescale_d = prescale_q + `PRESCALE_ONE;
            end
        end
    end

    // Control and status: a match sets the flag over a write
    always @* begin
        ctrl_status_d = ctrl_status_q;
        if (!standby) begin
            if (wr_refresh_timer_ctrl) begin
                ctrl_status_d = wr_data;
            end
            if (match) begin
                ctrl_status_d[`CTRL_MATCH_FLAG_BIT] = 1'h1;
            end
        end
    end

    // Timer counter: hardware update wins over a write
    always @* begin
        timer_counter_d = timer_counter_q;
        if (!standby) begin
            if (match) begin
                timer_counter_d = `COUNT_ZERO;
            end else if (tick) begin
                timer_counter_d = timer_counter_q + `COUNT_ONE;
            end else if (wr_refresh_timer_counter) begin
                timer_counter_d = wr_data;
            end
        end
    end

    // Refresh count: a match wins over a write
    always @* begin
        refresh_count_d = refresh_count_q;
        if (!standby) begin
            if (match) begin
                refresh_count_d = refresh_count_q + `COUNT_ONE;
            end else if (wr_refresh_count) begin
                refresh_count_d = wr_data;
            end
        end
    end

    // Request pulse for one cycle after each match
    always @* begin
        refresh_request_d = 1'h0;
        if (!standby && match) begin
            refresh_request_d = 1'h1;
        end
    end

    // Running registers keep going through manual reset and sleep
    always @(posedge ref_clk) begin
        if (reset) begin
            ctrl_status_q <= `RST_REFRESH_TIMER_CTRL;
        end else begin
            ctrl_status_q <= ctrl_status_d;
        end
    end

    always @(posedge ref_clk) begin
        if (reset) begin
            timer_counter_q <= `RST_REFRESH_TIMER_COUNTER;
        end else begin
            timer_counter_q <= timer_counter_d;
        end
    end

    always @(posedge ref_clk) begin
        if (reset) begin
            refresh_count_q <= `RST_REFRESH_COUNT;
        end else begin
            refresh_count_q <= refresh_count_d;
        end
    end

    always @(posedge ref_clk) begin
        if (reset) begin
            prescale_q <= `PRESCALE_ZERO;
        end else begin
            prescale_q <= prescale_d;
        end
    end

    always @(posedge ref_clk) begin
        if (reset) begin
            refresh_request_q <= 1'h0;
        end else begin
            refresh_request_q <= refresh_request_d;
        end
    end

    assign bus_control_one           = bus_control_one_q;
    assign bus_control_two           = bus_control_two_q;
    assign wait_control_one          = wait_control_one_q;
    assign wait_control_two          = wait_control_two_q;
    assign memory_control            = memory_control_q;
    assign second_memory_control     = second_memory_control_q;
    assign card_interface_control    = card_interface_control_q;
    assign refresh_timer_ctrl_status = ctrl_status_q;
    assign refresh_timer_counter     = timer_counter_q;
    assign refresh_time_constant     = time_constant_q;
    assign refresh_count             = refresh_count_q;
    assign port_control              = port_control_q;
    assign port_data                 = port_data_q;
    assign refresh_request           = refresh_request_q;

endmodule // bus_state_unit

// [hw/bus_state_unit_defs.vh]
// Constants for the bus state unit register set
`ifndef BUS_STATE_UNIT_DEFS_VH
`define BUS_STATE_UNIT_DEFS_VH

// Register select codes on wr_sel
`define SEL_BUS_CONTROL_ONE          4'h0
`define SEL_BUS_CONTROL_TWO          4'h1
`define SEL_WAIT_CONTROL_ONE         4'h2
`define SEL_WAIT_CONTROL_TWO         4'h3
`define SEL_MEMORY_CONTROL           4'h4
`define SEL_SECOND_MEMORY_CONTROL    4'h5
`define SEL_CARD_INTERFACE_CONTROL   4'h6
`define SEL_REFRESH_TIMER_CTRL       4'h7
`define SEL_REFRESH_TIMER_COUNTER    4'h8
`define SEL_REFRESH_TIME_CONSTANT    4'h9
`define SEL_REFRESH_COUNT            4'hA
`define SEL_PORT_CONTROL             4'hB
`define SEL_PORT_DATA                4'hC

// Power-on values
`define RST_BUS_CONTROL_ONE          16'h0000
`define RST_BUS_CONTROL_TWO          16'h3FFC
`define RST_WAIT_CONTROL_ONE         16'h3FFF
`define RST_WAIT_CONTROL_TWO         16'hFFFF
`define RST_MEMORY_CONTROL           16'h0000
`define RST_SECOND_MEMORY_CONTROL    16'h0000
`define RST_CARD_INTERFACE_CONTROL   16'h0000
`define RST_REFRESH_TIMER_CTRL       16'h0000
`define RST_REFRESH_TIMER_COUNTER    16'h0000
`define RST_REFRESH_TIME_CONSTANT    16'h0000
`define RST_REFRESH_COUNT            16'h0000
`define RST_PORT_CONTROL             16'h0000

// Refresh timer control and status fields
`define CTRL_MATCH_FLAG_BIT          7
`define CTRL_CLOCK_SEL_HI            5
`define CTRL_CLOCK_SEL_LO            3
`define CTRL_CLOCK_SEL_OFF           3'h0

// Counter step and clear values
`define COUNT_ONE                    16'h0001
`define COUNT_ZERO                   16'h0000
`define PRESCALE_ONE                 8'h01
`define PRESCALE_ZERO                8'h00

`endif

// [verif/bus_state_unit_monitor.sv]
// Checker for bus state unit reset and retention behaviour
`timescale 1ns/1ps
module bus_state_unit_monitor #(
    parameter [7:0] PRESCALE = 8'h04
) (
    input wire        ref_clk,
    input wire        reset,
    input wire        manual_reset,
    input wire        standby,
    input wire        sleep,
    input wire        wr_en,
    input wire [3:0]  wr_sel,
    input wire [15:0] wr_data,
    input wire [15:0] bus_control_one,
    input wire [15:0] bus_control_two,
    input wire [15:0] wait_control_one,
    input wire [15:0] wait_control_two,
    input wire [15:0] memory_control,
    input wire [15:0] second_memory_control,
    input wire [15:0] card_interface_control,
    input wire [15:0] refresh_timer_ctrl_status,
    input wire [15:0] refresh_timer_counter,
    input wire [15:0] refresh_time_constant,
    input wire [15:0] refresh_count,
    input wire [15:0] port_control,
    input wire [15:0] port_data,
    input wire        refresh_request
);
    wire [159:0] cfg_all = {bus_control_one, bus_control_two, wait_control_one, wait_control_two,
        memory_control, second_memory_control, card_interface_control, refresh_time_constant,
        port_control, port_data};
    default clocking cb @(posedge ref_clk); endclocking
    sequence s_held;
        $stable(cfg_all);
    endsequence
    sequence s_tick;
        !$past(reset) && !$past(wr_en) && $changed(refresh_count);
    endsequence
    property p_hold(m);
        disable iff (reset) m |=> s_held;
    endproperty
    AST_CFG_POR:
    assert property (reset |=> cfg_all[159:96] == 64'h00003FFC3FFFFFFF) else $error("cfg por");
    AST_MEM_POR:
    assert property (reset |=> cfg_all[95:16] == 80'h0) else $error("mem por");
    AST_TMR_POR:
    assert property (reset |=> {refresh_timer_ctrl_status, refresh_timer_counter,
        refresh_count} == 48'h0) else $error("timer por");
    AST_MANUAL_HOLD:
    assert property (p_hold(manual_reset)) else $error("manual hold");
    AST_STANDBY_HOLD:
    assert property (p_hold(standby)) else $error("standby hold");
    AST_SLEEP_HOLD:
    assert property (p_hold(sleep)) else $error("sleep hold");
    AST_TMR_FREEZE:
    assert property (disable iff (reset) standby |=> $stable({refresh_timer_ctrl_status,
        refresh_timer_counter, refresh_count})) else $error("timer freeze");
    AST_COUNT_STEP:
    assert property (disable iff (reset) s_tick |-> refresh_count == $past(refresh_count)
        + 16'h0001) else $error("count step");
    AST_REQ_PULSE:
    assert property (disable iff (reset) refresh_request |=> !refresh_request) else $error("req");
endmodule // bus_state_unit_monitor
bind bus_state_unit bus_state_unit_monitor #(
    .PRESCALE(PRESCALE)
) i_monitor (
    .ref_clk                  (ref_clk),
    .reset                    (reset),
    .manual_reset             (manual_reset),
    .standby                  (standby),
    .sleep                    (sleep),
    .wr_en                    (wr_en),
    .wr_sel                   (wr_sel),
    .wr_data                  (wr_data),
    .bus_control_one          (bus_control_one),
    .bus_control_two          (bus_control_two),
    .wait_control_one         (wait_control_one),
    .wait_control_two         (wait_control_two),
    .memory_control           (memory_control),
    .second_memory_control    (second_memory_control),
    .card_interface_control   (card_interface_control),
    .refresh_timer_ctrl_status(refresh_timer_ctrl_status),
    .refresh_timer_counter    (refresh_timer_counter),
    .refresh_time_constant    (refresh_time_constant),
    .refresh_count            (refresh_count),
    .port_control             (port_control),
    .port_data                (port_data),
    .refresh_request          (refresh_request)
);

// [verif/tb_bus_state_unit.sv]
// Self-checking bench for the bus state unit
`timescale 1ns/1ps
module tb_bus_state_unit;
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic        manual_reset = 1'b0;
    logic        standby = 1'b0;
    logic        sleep = 1'b0;
    logic        wr_en = 1'b0;
    logic [3:0]  wr_sel = 4'h0;
    logic [15:0] wr_data = 16'h0000;
    wire [15:0]  bus_control_one, bus_control_two, wait_control_one, wait_control_two,
        memory_control, second_memory_control, card_interface_control, refresh_count,
        refresh_timer_ctrl_status, refresh_timer_counter, refresh_time_constant,
        port_control, port_data;
    wire         refresh_request;
    wire [207:0] all_q = {port_data, port_control, refresh_count, refresh_time_constant,
        refresh_timer_counter, refresh_timer_ctrl_status, card_interface_control,
        second_memory_control, memory_control, wait_control_two, wait_control_one,
        bus_control_two, bus_control_one};
    integer      errors = 0;
    integer      n_compared = 0;
    integer      cycles = 0;
    localparam [191:0] POR_VALUES = {128'h0, 64'hFFFF3FFF3FFC0000};
    bus_state_unit #(
        .PRESCALE(8'h02)
    ) i_dut (
        .ref_clk                  (ref_clk),
        .reset                    (reset),
        .manual_reset             (manual_reset),
        .standby                  (standby),
        .sleep                    (sleep),
        .wr_en                    (wr_en),
        .wr_sel                   (wr_sel),
        .wr_data                  (wr_data),
        .bus_control_one          (bus_control_one),
        .bus_control_two          (bus_control_two),
        .wait_control_one         (wait_control_one),
        .wait_control_two         (wait_control_two),
        .memory_control           (memory_control),
        .second_memory_control    (second_memory_control),
        .card_interface_control   (card_interface_control),
        .refresh_timer_ctrl_status(refresh_timer_ctrl_status),
        .refresh_timer_counter    (refresh_timer_counter),
        .refresh_time_constant    (refresh_time_constant),
        .refresh_count            (refresh_count),
        .port_control             (port_control),
        .port_data                (port_data),
        .refresh_request          (refresh_request)
    );
    initial forever #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            errors = errors + 1;
            complete_run;
        end
    end
    task automatic chk(input [15:0] got, input [15:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input [3:0] s, input [15:0] d);
        @(negedge ref_clk);
        wr_en = 1'b1;
        wr_sel = s;
        wr_data = d;
        @(negedge ref_clk);
        wr_en = 1'b0;
    endtask
    task automatic t_por;
        integer i;
        for (i = 0; i < 12; i = i + 1)
            chk(all_q[i*16 +: 16], POR_VALUES[i*16 +: 16]); // to
        $display("test por done");
    endtask
    task automatic t_retain;
        integer s;
        integer m;
        for (s = 0; s < 13; s = s + 1)
            if (s != 7 && s != 8 && s != 10) wr(s[3:0], {s[3:0], ~s[3:0], 8'h5A});
        for (m = 0; m < 3; m = m + 1) begin
            @(negedge ref_clk);
            {standby, sleep, manual_reset} = 3'h1 << m;
            for (s = 0; s < 13; s = s + 1)
                wr(s[3:0], 16'h0F0F);
            {standby, sleep, manual_reset} = 3'h0;
            for (s = 0; s < 13; s = s + 1)
                if (s != 7 && s != 8 && s != 10)
                    chk(all_q[s*16 +: 16], {s[3:0], ~s[3:0], 8'h5A}); // to
        end
        reset = 1'b1;
        @(negedge ref_clk);
        reset = 1'b0;
        t_por;
        $display("test retain done");
    endtask
    task automatic t_timer;
        logic [15:0] c;
        logic [15:0] r;
        logic [15:0] k;
        integer      p;
        integer      n;
        p = 0;
        wr(4'h9, 16'h0003);
        wr(4'h7, 16'h0008);
        sleep = 1'b1;
        c = refresh_timer_counter;
        repeat (2) @(negedge ref_clk);
        chk({15'h0000, refresh_timer_counter !== c}, 16'h0001);
        sleep = 1'b0;
        manual_reset = 1'b1;
        r = refresh_count;
        for (n = 0; n < 22; n = n + 1) begin
            @(negedge ref_clk);
            if (refresh_request === 1'b1)
                p = p + 1;
        end
        chk(refresh_count, r + 16'h0003);
        chk(p[15:0], 16'h0003);
        chk({15'h0000, refresh_timer_ctrl_status[7]}, 16'h0001);
        manual_reset = 1'b0;
        standby = 1'b1;
        c = refresh_timer_counter;
        r = refresh_count;
        k = refresh_timer_ctrl_status;
        repeat (6) @(negedge ref_clk);
        chk(refresh_timer_counter, c);
        chk(refresh_count, r);
        chk(refresh_timer_ctrl_status, k);
        standby = 1'b0;
        wr(4'h7, 16'h0008);
        chk({15'h0000, refresh_timer_ctrl_status[7]}, 16'h0000);
        $display("test timer done");
    endtask
    task complete_run;
        $display("compared=%0d errors=%0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge ref_clk);
        reset = 1'b0;
        t_por;
        t_retain;
        t_timer;
        complete_run;
    end
endmodule // tb_bus_state_unit
